/* hdl/vout_target_defs.vh */
// Command codes, reset values and limits of the output voltage target bank
`ifndef VOUT_TARGET_DEFS_VH
`define VOUT_TARGET_DEFS_VH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define CMD_NOMINAL_SETPOINT   8'h21
`define CMD_OUTPUT_TRIM_OFFSET 8'h22
`define CMD_OUTPUT_UPPER_LIMIT 8'h24
`define CMD_MARGIN_HIGH_SETPT  8'h25
`define CMD_MARGIN_LOW_SETPT   8'h26
`define CMD_OUTPUT_SLEW_RATE   8'h27
`define CMD_LOAD_LINE_DROOP    8'h28
`define CMD_OUTPUT_LOWER_LIMIT 8'h2b
`define CMD_COMMIT_STAGED      8'he7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_NOMINAL_SETPOINT   16'h0384
`define RST_OUTPUT_TRIM_OFFSET 16'h0000
`define RST_OUTPUT_UPPER_LIMIT 16'h08fc
`define RST_MARGIN_HIGH_SETPT  16'h0640
`define RST_MARGIN_LOW_SETPT   16'h00fa
`define RST_OUTPUT_SLEW_RATE   16'h0064
`define RST_LOAD_LINE_DROOP    16'h0000
`define RST_OUTPUT_LOWER_LIMIT 16'h0000

// ----------------------------------------------------------------
// Ranges
// ----------------------------------------------------------------
`define TRIM_LIMIT_MV          16'h00fa
`define UPPER_LIMIT_MAX_MV     16'h0b22
`define SLEW_MIN_COUNT         16'h0001
`define SLEW_MAX_COUNT         16'h03e8
`define DROOP_MAX_COUNT        16'h0640

// ----------------------------------------------------------------
// Set point source select
// ----------------------------------------------------------------
`define SRC_NOMINAL            2'h0
`define SRC_MARGIN_LOW         2'h1
`define SRC_MARGIN_HIGH        2'h2

`endif

/* hdl/vout_target_regs.v */
// Paged output voltage target registers with staged slew and droop
`timescale 1ns/10ps
`default_nettype none
`include "vout_target_defs.vh"

module vout_target_regs #(
	parameter PAGES  = 2,
	parameter PAGE_W = 1
) (
	// Clock and reset
	input  wire                  mclk,
	input  wire                  rst_b,
	// Command port from the serial bus engine
	input  wire                  cmdWrite,
	input  wire                  cmdRead,
	input  wire [7:0]            cmdCode,
	input  wire [PAGE_W-1:0]     cmdPage,
	input  wire [15:0]           cmdWrData,
	output reg  [15:0]           cmdRdData,
	output reg                   cmdRdValid,
	output reg                   cmdUnknown,
	// Set point source per page, two bits each
	input  wire [2*PAGES-1:0]    spSource,
	// Regulator loop settings per page, sixteen bits each
	output reg  [16*PAGES-1:0]   targetMv,
	output reg  [16*PAGES-1:0]   slewActive,
	output reg  [16*PAGES-1:0]   droopActive
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	reg [15:0] nomMem   [0:PAGES-1];
	reg [15:0] trimMem  [0:PAGES-1];
	reg [15:0] upperMem [0:PAGES-1];
	reg [15:0] mhMem    [0:PAGES-1];
	reg [15:0] mlMem    [0:PAGES-1];
	reg [15:0] slewMem  [0:PAGES-1];
	reg [15:0] droopMem [0:PAGES-1];
	reg [15:0] lowerMem [0:PAGES-1];

	integer i;

	// ----------------------------------------------------------------
	// Write range limits
	// ----------------------------------------------------------------
	// Write values held to their legal ranges on entry, so a
	// readback shows what the loop will really use, save a lower limit set above the upper limit
	wire [15:0] upperWr;
	wire [15:0] slewWr;
	wire [15:0] droopWr;
	wire [15:0] trimWr;
	wire        trimNeg;

	assign upperWr = (cmdWrData > `UPPER_LIMIT_MAX_MV) ?
		`UPPER_LIMIT_MAX_MV : cmdWrData;
	assign slewWr = (cmdWrData < `SLEW_MIN_COUNT) ? `SLEW_MIN_COUNT :
		((cmdWrData > `SLEW_MAX_COUNT) ?
		`SLEW_MAX_COUNT : cmdWrData);
	assign droopWr = (cmdWrData > `DROOP_MAX_COUNT) ?
		`DROOP_MAX_COUNT : cmdWrData;
	assign trimNeg = cmdWrData[15];
	assign trimWr = trimNeg ?
		(((16'h0000 - cmdWrData) > `TRIM_LIMIT_MV) ?
		(16'h0000 - `TRIM_LIMIT_MV) : cmdWrData) :
		((cmdWrData > `TRIM_LIMIT_MV) ?
		`TRIM_LIMIT_MV : cmdWrData);

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	reg        known;
	reg [15:0] rdSel;

	always @*
	begin
		known = 1'b1;
		rdSel = 16'h0000;
		case (cmdCode)
			`CMD_NOMINAL_SETPOINT:   rdSel = nomMem[cmdPage];
			`CMD_OUTPUT_TRIM_OFFSET: rdSel = trimMem[cmdPage];
			`CMD_OUTPUT_UPPER_LIMIT: rdSel = upperMem[cmdPage];
			`CMD_MARGIN_HIGH_SETPT:  rdSel = mhMem[cmdPage];
			`CMD_MARGIN_LOW_SETPT:   rdSel = mlMem[cmdPage];
			`CMD_OUTPUT_SLEW_RATE:   rdSel = slewMem[cmdPage];
			`CMD_LOAD_LINE_DROOP:    rdSel = droopMem[cmdPage];
			`CMD_OUTPUT_LOWER_LIMIT: rdSel = lowerMem[cmdPage];
			`CMD_COMMIT_STAGED:      rdSel = 16'h0000;
			default:                 known = 1'b0;
		endcase
	end

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (i = 0; i < PAGES; i = i + 1)
			begin
				nomMem[i]   <= `RST_NOMINAL_SETPOINT;
				trimMem[i]  <= `RST_OUTPUT_TRIM_OFFSET;
				upperMem[i] <= `RST_OUTPUT_UPPER_LIMIT;
				mhMem[i]    <= `RST_MARGIN_HIGH_SETPT;
				mlMem[i]    <= `RST_MARGIN_LOW_SETPT;
				slewMem[i]  <= `RST_OUTPUT_SLEW_RATE;
				droopMem[i] <= `RST_LOAD_LINE_DROOP;
				lowerMem[i] <= `RST_OUTPUT_LOWER_LIMIT;
			end
			cmdRdData  <= 16'h0000;
			cmdRdValid <= 1'b0;
			cmdUnknown <= 1'b0;
		end
		else
		begin
			cmdRdValid <= cmdRead;
			cmdRdData  <= cmdRead ? rdSel : 16'h0000;
			cmdUnknown <= (cmdRead | cmdWrite) & ~known;
			if (cmdWrite)
			begin
				// Each page keeps its own copy
				case (cmdCode)
					`CMD_NOMINAL_SETPOINT:
						nomMem[cmdPage] <= cmdWrData;
					`CMD_OUTPUT_TRIM_OFFSET:
						trimMem[cmdPage] <= trimWr;
					`CMD_OUTPUT_UPPER_LIMIT:
						upperMem[cmdPage] <= upperWr;
					`CMD_MARGIN_HIGH_SETPT:
						mhMem[cmdPage] <= cmdWrData;
					`CMD_MARGIN_LOW_SETPT:
						mlMem[cmdPage] <= cmdWrData;
					`CMD_OUTPUT_SLEW_RATE:
						slewMem[cmdPage] <= slewWr;
					`CMD_LOAD_LINE_DROOP:
						droopMem[cmdPage] <= droopWr;
					`CMD_OUTPUT_LOWER_LIMIT:
						lowerMem[cmdPage] <= cmdWrData;
					default:
						;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Staged settings and target per page
	// ----------------------------------------------------------------
	// Commit carries no page; it applies every page at once so
	// that both outputs change rate and droop on the same edge
	wire commit;

	assign commit = cmdWrite & (cmdCode == `CMD_COMMIT_STAGED);

	// Target is registered; a write shows on it one edge later

	genvar g;
	generate
		for (g = 0; g < PAGES; g = g + 1)
		begin : pageGen
			reg  [15:0]        spSel;
			wire signed [17:0] sum;
			wire [15:0]        sumPos;
			wire [15:0]        belowUpper;
			wire [15:0]        tgtNxt;

			always @*
			begin
				case (spSource[2*g+1:2*g])
					`SRC_MARGIN_LOW:  spSel = mlMem[g];
					`SRC_MARGIN_HIGH: spSel = mhMem[g];
					default:          spSel = nomMem[g];
				endcase
			end

			// Trim first, then clamp; the upper limit wins a conflict
			assign sum = $signed({2'b00, spSel}) +
				$signed({{2{trimMem[g][15]}}, trimMem[g]});
			assign sumPos = sum[17] ? 16'h0000 :
				(sum[16] ? 16'hffff : sum[15:0]);
			assign belowUpper = (sumPos > upperMem[g]) ?
				upperMem[g] : sumPos;
			assign tgtNxt = (belowUpper < lowerMem[g]) ?
				((lowerMem[g] > upperMem[g]) ? upperMem[g] : lowerMem[g])
				: belowUpper;

			always @(posedge mclk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					targetMv[16*g+15:16*g]    <= `RST_NOMINAL_SETPOINT;
					slewActive[16*g+15:16*g]  <= `RST_OUTPUT_SLEW_RATE;
					droopActive[16*g+15:16*g] <= `RST_LOAD_LINE_DROOP;
				end
				else
				begin
					targetMv[16*g+15:16*g] <= tgtNxt;
					// Loop sees new rate and droop only on commit
					if (commit)
					begin
						slewActive[16*g+15:16*g]  <= slewMem[g];
						droopActive[16*g+15:16*g] <= droopMem[g];
					end
				end
			end
		end
	endgenerate

endmodule // vout_target_regs
`default_nettype wire

/* sim/vout_target_checker.sv */
// Port assertions for the output voltage target bank
`timescale 1ns/10ps
`default_nettype none
module vout_target_checker #(
	parameter PAGES  = 2,
	parameter PAGE_W = 1
) (
	// Clock and reset
	input wire logic               mclk,
	input wire logic               rst_b,
	// Command port
	input wire logic               cmdWrite,
	input wire logic               cmdRead,
	input wire logic [7:0]         cmdCode,
	input wire logic [PAGE_W-1:0]  cmdPage,
	input wire logic [15:0]        cmdWrData,
	input wire logic [15:0]        cmdRdData,
	input wire logic               cmdRdValid,
	input wire logic               cmdUnknown,
	// Loop side
	input wire logic [2*PAGES-1:0] spSource,
	input wire logic [16*PAGES-1:0] targetMv,
	input wire logic [16*PAGES-1:0] slewActive,
	input wire logic [16*PAGES-1:0] droopActive
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	property p_rdValid; cmdRead |=> cmdRdValid; endproperty
	a_rdValid: assert property (p_rdValid)
		else $error("read not answered");
	property p_rdQuiet; !cmdRead |=> !cmdRdValid && cmdRdData == 16'h0000; endproperty
	a_rdQuiet: assert property (p_rdQuiet)
		else $error("read data without read");
	property p_unknown; (cmdRead || cmdWrite) && cmdCode == 8'h23 |=> cmdUnknown; endproperty
	a_unknown: assert property (p_unknown)
		else $error("unknown code not flagged");
	property p_upper; targetMv[15:0] <= 16'h0b22; endproperty
	a_upper: assert property (p_upper)
		else $error("target above ceiling");
	property p_hold; !(cmdWrite && cmdCode == 8'he7) |=> $stable(slewActive) && $stable(droopActive); endproperty
	a_hold: assert property (p_hold)
		else $error("applied value moved without commit");
	property p_slew; slewActive[15:0] >= 16'h0001 && slewActive[15:0] <= 16'h03e8; endproperty
	a_slew: assert property (p_slew)
		else $error("slew out of range");
	property p_droop; droopActive[15:0] <= 16'h0640; endproperty
	a_droop: assert property (p_droop)
		else $error("droop out of range");
	property p_tgtHold; !cmdWrite[*3] ##0 $stable(spSource) |=> !$stable(spSource) || $stable(targetMv); endproperty
	a_tgtHold: assert property (p_tgtHold)
		else $error("target moved with quiet inputs");
endmodule // vout_target_checker
`default_nettype wire

/* sim/vout_target_host.sv */
// Host model driving the command port
`timescale 1ns/10ps
`default_nettype none
module vout_target_host (
	// Clock
	input  wire logic        mclk,
	// Command port
	output var  logic        cmdWrite,
	output var  logic        cmdRead,
	output var  logic [7:0]  cmdCode,
	output var  logic [0:0]  cmdPage,
	output var  logic [15:0] cmdWrData,
	input  wire logic [15:0] cmdRdData
);
	initial
	begin
		cmdWrite = 1'b0;
		cmdRead = 1'b0;
		cmdCode = 8'h00;
		cmdPage = 1'b0;
		cmdWrData = 16'h0000;
	end
	// One strobe across one rising edge; commit is a dataless write
	task automatic xfer(input logic w, input logic [7:0] code,
		input logic [15:0] data, output logic [15:0] q);
		@(negedge mclk);
		cmdCode = code;
		cmdWrData = data;
		cmdWrite = w;
		cmdRead = !w;
		@(negedge mclk);
		q = cmdRdData;
		cmdWrite = 1'b0;
		cmdRead = 1'b0;
		cmdWrData = ~data; // Idle data never repeats the last word
	endtask
endmodule // vout_target_host
`default_nettype wire

/* sim/test_output_voltage_target_regs.sv */
// Self-checking bench for the output voltage target bank
`timescale 1ns/10ps
`default_nettype none
module test_output_voltage_target_regs;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic        cmdWrite, cmdRead, cmdRdValid, cmdUnknown;
	logic [7:0]  cmdCode;
	logic [0:0]  cmdPage;
	logic [15:0] cmdWrData, cmdRdData, q;
	logic [3:0]  spSource = 4'h0;
	logic [31:0] targetMv, slewActive, droopActive;
	int          n_errors = 0;
	int          cmp_count = 0;
	// Code, write data, readback; top nibble set means write first
	logic [43:0] rows [17] = '{44'h0_21_0000_0384, 44'h0_22_0000_0000,
		44'h0_24_0000_08fc, 44'h0_25_0000_0640, 44'h0_26_0000_00fa,
		44'h0_27_0000_0064, 44'h0_28_0000_0000, 44'h0_2b_0000_0000,
		44'h1_22_0190_00fa, 44'h1_22_fe70_ff06, 44'h1_24_0c00_0b22,
		44'h1_25_0700_0700, 44'h1_26_0100_0100, 44'h1_27_0000_0001,
		44'h1_28_0700_0640, 44'h1_2b_0010_0010, 44'h1_21_0400_0400};
	logic [15:0] tgt [3] = '{16'h0306, 16'h0010, 16'h0606};
	always #2 mclk = ~mclk;
	vout_target_host u_host (.mclk(mclk), .cmdWrite(cmdWrite),
		.cmdRead(cmdRead), .cmdCode(cmdCode), .cmdPage(cmdPage),
		.cmdWrData(cmdWrData), .cmdRdData(cmdRdData));
	vout_target_regs u_dut (.mclk(mclk), .rst_b(rst_b), .cmdWrite(cmdWrite),
		.cmdRead(cmdRead), .cmdCode(cmdCode), .cmdPage(cmdPage),
		.cmdWrData(cmdWrData), .cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid),
		.cmdUnknown(cmdUnknown), .spSource(spSource), .targetMv(targetMv),
		.slewActive(slewActive), .droopActive(droopActive));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(negedge mclk);
		check(targetMv, 32'h0384_0384);
		check(slewActive, 32'h0064_0064);
		check({cmdRdData, 15'h0, cmdRdValid}, 32'h0);
		$display("reset test done");
		rst_b = 1'b1;
		foreach (rows[i])
		begin
			if (rows[i][40])
				u_host.xfer(1'b1, rows[i][39:32], rows[i][31:16], q);
			u_host.xfer(1'b0, rows[i][39:32], 16'h0000, q);
			check({16'h0, q}, {16'h0, rows[i][15:0]});
		end
		$display("register table done");
		check(slewActive, 32'h0064_0064);
		u_host.xfer(1'b1, 8'he7, 16'h0000, q);
		@(negedge mclk);
		check(slewActive, 32'h0064_0001);
		check(droopActive, 32'h0000_0640);
		foreach (tgt[s])
		begin
			spSource = {2'h0, s[1:0]};
			repeat (3) @(negedge mclk);
			check(targetMv, {16'h0384, tgt[s]});
		end
		u_host.xfer(1'b1, 8'h24, 16'h0500, q);
		repeat (3) @(negedge mclk);
		check(targetMv, 32'h0384_0500);
		u_host.xfer(1'b0, 8'h23, 16'h0000, q);
		check({q, 15'h0, cmdUnknown}, 32'h0000_0001);
		check({31'h0, cmdRdValid}, 32'h0000_0001);
		$display("target and refusal done");
		// Second page keeps its own copy
		@(negedge mclk);
		u_host.cmdPage = 1'b1;
		u_host.xfer(1'b0, 8'h24, 16'h0000, q);
		check({16'h0, q}, 32'h0000_08fc);
		u_host.xfer(1'b1, 8'h21, 16'h0500, q);
		u_host.xfer(1'b0, 8'h21, 16'h0000, q);
		check({16'h0, q}, 32'h0000_0500);
		repeat (3) @(negedge mclk);
		check(targetMv, 32'h0500_0500);
		$display("page test done");
		conclude();
	end
	initial
	begin
		#20000;
		n_errors++;
		conclude();
	end
endmodule // test_output_voltage_target_regs
bind vout_target_regs vout_target_checker #(.PAGES(PAGES), .PAGE_W(PAGE_W)) u_chk (
	.mclk(mclk), .rst_b(rst_b), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
	.cmdCode(cmdCode), .cmdPage(cmdPage), .cmdWrData(cmdWrData),
	.cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid), .cmdUnknown(cmdUnknown),
	.spSource(spSource), .targetMv(targetMv), .slewActive(slewActive),
	.droopActive(droopActive));
`default_nettype wire
